//--- pkg/rrs_pkg.sv
// Package for the reset release sequencer: timing constants, states and carriers.
// Assumes a 40 MHz system clock.
package rrs_pkg;
    localparam int unsigned CLK_PERIOD_PS = 25000;
    // Initialization interval in nanoseconds; plain default, board dependent.
    localparam int unsigned INIT_TIME_NS = 1000;
    localparam int unsigned INIT_CYCLES =
        (INIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Least warm reset pin low time, in nanoseconds (17.2 us).
    localparam int unsigned PIN_LOW_MIN_NS = 17200;
    localparam int unsigned PIN_LOW_MIN_CYCLES =
        (PIN_LOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

    typedef enum logic [1:0] {
        RRS_ST_INIT,
        RRS_ST_HOLD,
        RRS_ST_RUN,
        RRS_ST_DEEP
    } rrs_state_t;

    // Reset requests from the supply monitors and the pin.
    typedef struct packed {
        logic por_active;
        logic lvd_active;
        logic ext_reset_n;
    } rrs_req_t;

    // Status reported to the system.
    typedef struct packed {
        logic main_reset;
        logic main_power_on;
        logic cpu_run;
        logic single_boot;
    } rrs_stat_t;
endpackage

//--- rtl/rrs_sequencer.sv
// Reset release sequencer: merges power-on, low-voltage and pin resets into
// one main-domain reset, and handles exit from deep stop mode.
// Assumes all inputs are synchronous to clk and the power-on detector drives reset.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Hold reset until initialization interval elapses.
// - Extend reset while pin still low.
// - Early pin release still waits full interval.
// - Processor runs only after reset release.
// - Low-voltage detector keeps device in reset.
// - Pin low or detector ends deep stop.
// - Deep stop exit powers and resets main domain.
// - Resume normal mode after request clears.
// - Power-on detector resets on power up and down.
module rrs_sequencer #(
    parameter int unsigned INIT_CYCLES = rrs_pkg::INIT_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire rrs_pkg::rrs_req_t req,
    input wire logic boot_select_n,
    input wire logic deep_stop_mode,
    output rrs_pkg::rrs_stat_t stat
);
    localparam logic [rrs_pkg::CNT_W-1:0] INIT_LAST = rrs_pkg::CNT_W'(INIT_CYCLES - 1);

    rrs_pkg::rrs_state_t state_reg;
    rrs_pkg::rrs_state_t state_next;
    logic [rrs_pkg::CNT_W-1:0] cnt_reg;
    logic [rrs_pkg::CNT_W-1:0] cnt_next;
    rrs_pkg::rrs_stat_t stat_next;
    logic hold_req;
    logic init_done;

    // Power-on detector acts during both ramp up and ramp down.
    assign hold_req = req.por_active | req.lvd_active | ~req.ext_reset_n;
    assign init_done = (cnt_reg == INIT_LAST);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            rrs_pkg::RRS_ST_INIT: begin
                // The interval restarts while the power-on detector is active.
                if (req.por_active) begin
                    cnt_next = rrs_pkg::CNT_RESET;
                end else if (init_done) begin
                    state_next = rrs_pkg::RRS_ST_HOLD;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            rrs_pkg::RRS_ST_HOLD: begin
                if (req.por_active) begin
                    // A supply dip while held restarts the whole interval.
                    state_next = rrs_pkg::RRS_ST_INIT;
                    cnt_next = rrs_pkg::CNT_RESET;
                end else if (!hold_req) begin
                    state_next = rrs_pkg::RRS_ST_RUN;
                end
            end
            rrs_pkg::RRS_ST_RUN: begin
                if (req.por_active) begin
                    state_next = rrs_pkg::RRS_ST_INIT;
                    cnt_next = rrs_pkg::CNT_RESET;
                end else if (hold_req) begin
                    state_next = rrs_pkg::RRS_ST_HOLD;
                end else if (deep_stop_mode) begin
                    state_next = rrs_pkg::RRS_ST_DEEP;
                end
            end
            rrs_pkg::RRS_ST_DEEP: begin
                if (req.por_active) begin
                    state_next = rrs_pkg::RRS_ST_INIT;
                    cnt_next = rrs_pkg::CNT_RESET;
                end else if (hold_req) begin
                    // Deep stop exit is a reset path: no warm-up, normal mode after.
                    state_next = rrs_pkg::RRS_ST_HOLD;
                end
            end
            default: begin
                state_next = rrs_pkg::RRS_ST_INIT;
                cnt_next = rrs_pkg::CNT_RESET;
            end
        endcase
    end

    always_comb begin
        stat_next.main_reset = (state_next != rrs_pkg::RRS_ST_RUN) &&
                               (state_next != rrs_pkg::RRS_ST_DEEP);
        stat_next.main_power_on = (state_next != rrs_pkg::RRS_ST_DEEP);
        stat_next.cpu_run = (state_next == rrs_pkg::RRS_ST_RUN);
        // Boot select is sampled while reset is held, latched at release.
        stat_next.single_boot = stat.single_boot;
        if (state_reg == rrs_pkg::RRS_ST_HOLD && state_next == rrs_pkg::RRS_ST_RUN) begin
            stat_next.single_boot = ~boot_select_n;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= rrs_pkg::RRS_ST_INIT;
            cnt_reg <= rrs_pkg::CNT_RESET;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // Release happens only on a clock edge, so the whole domain leaves together.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stat <= '{main_reset: 1'b1, main_power_on: 1'b1, cpu_run: 1'b0,
                      single_boot: 1'b0};
        end else begin
            stat <= stat_next;
        end
    end

    // Pin low time is only enforced by the board model, which stretches pin pulses; the device tolerates any width.
    property p_init_hold;
        @(posedge clk) disable iff (reset)
        (state_reg == rrs_pkg::RRS_ST_INIT) |=> stat.main_reset;
    endproperty
    a_init_hold: assert property (p_init_hold) else $error("reset released during init");

    property p_por_restart;
        @(posedge clk) disable iff (reset)
        req.por_active |=> (state_reg == rrs_pkg::RRS_ST_INIT) && (cnt_reg == rrs_pkg::CNT_RESET);
    endproperty
    a_por_restart: assert property (p_por_restart) else $error("por did not restart init");

    property p_pin_extends;
        @(posedge clk) disable iff (reset)
        (state_reg == rrs_pkg::RRS_ST_HOLD && !req.ext_reset_n) |=> stat.main_reset;
    endproperty
    a_pin_extends: assert property (p_pin_extends) else $error("pin low not extending");

    property p_early_release;
        @(posedge clk) disable iff (reset)
        (state_reg == rrs_pkg::RRS_ST_INIT && !init_done) |=>
            (state_reg != rrs_pkg::RRS_ST_RUN) && stat.main_reset;
    endproperty
    a_early_release: assert property (p_early_release) else $error("early release");

    property p_cpu_after;
        @(posedge clk) disable iff (reset)
        stat.cpu_run |-> !stat.main_reset;
    endproperty
    a_cpu_after: assert property (p_cpu_after) else $error("cpu runs in reset");

    property p_lvd_hold;
        @(posedge clk) disable iff (reset)
        (req.lvd_active && state_reg != rrs_pkg::RRS_ST_DEEP) |=> !stat.cpu_run;
    endproperty
    a_lvd_hold: assert property (p_lvd_hold) else $error("lvd not holding");

    property p_deep_exit;
        @(posedge clk) disable iff (reset)
        (state_reg == rrs_pkg::RRS_ST_DEEP && hold_req) |=>
            stat.main_power_on && stat.main_reset;
    endproperty
    a_deep_exit: assert property (p_deep_exit) else $error("deep stop exit wrong");

    property p_resume;
        @(posedge clk) disable iff (reset)
        (state_reg == rrs_pkg::RRS_ST_HOLD && !hold_req) |=> stat.cpu_run;
    endproperty
    a_resume: assert property (p_resume) else $error("no resume");

    property p_por;
        @(posedge clk) disable iff (reset)
        req.por_active |=> stat.main_reset ##1 stat.main_reset;
    endproperty
    a_por: assert property (p_por) else $error("por not resetting");

    property p_sync_release;
        @(posedge clk) disable iff (reset)
        $fell(stat.main_reset) |-> $past(state_reg) == rrs_pkg::RRS_ST_HOLD;
    endproperty
    a_sync_release: assert property (p_sync_release) else $error("bad release");
endmodule

`default_nettype wire

//--- tb/rrs_board.sv
// Board model: supply monitors, reset pin source and boot strap.
// Assumes the bench steps its inputs with non-blocking writes at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module rrs_board (
    input wire logic clk,
    input wire logic por_in,
    input wire logic lvd_in,
    input wire logic pin_req,
    input wire logic boot_low,
    output rrs_pkg::rrs_req_t req,
    output logic boot_select_n
);
    logic pin_low = 1'b0;
    int low_cnt = 0;
    // With the supply up, a pin pulse is stretched to the least warm reset time.
    always @(negedge clk) begin
        if (pin_req || (pin_low && !por_in && low_cnt < rrs_pkg::PIN_LOW_MIN_CYCLES)) begin
            pin_low <= 1'b1;
            low_cnt <= low_cnt + 1;
        end else begin
            pin_low <= 1'b0;
            low_cnt <= 0;
        end
    end
    assign req = {por_in, lvd_in, !pin_low};
    assign boot_select_n = !boot_low;
endmodule
`default_nettype wire

//--- tb/tb_reset_release_sequencer.sv
// Bench for the reset release sequencer, with a cycle model of the reset states.
// Assumes the board model drives the request inputs.
`timescale 1ns/1ps
`default_nettype none
module tb_reset_release_sequencer;
    localparam int unsigned N = 4;
    logic clk = 0, reset = 1, por = 1, lvd = 0, pin = 0, boot = 0, deep = 0, sb = 0;
    rrs_pkg::rrs_req_t req;
    rrs_pkg::rrs_stat_t stat;
    logic boot_n;
    logic [3:0] exp_stat;
    int st = 0, cnt = 0, cyc = 0, fail_count = 0, checked = 0, seed = 72744, r;
    always #12.5 clk = ~clk;
    rrs_board board (.clk(clk), .por_in(por), .lvd_in(lvd), .pin_req(pin),
        .boot_low(boot), .req(req), .boot_select_n(boot_n));
    rrs_sequencer #(.INIT_CYCLES(N)) dut (.clk(clk), .reset(reset), .req(req),
        .boot_select_n(boot_n), .deep_stop_mode(deep), .stat(stat));
    // Model states: 0 init, 1 hold, 2 run, 3 deep stop.
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= 0;
            cnt <= 0;
            sb <= 0;
        end else if (req.por_active) begin
            st <= 0;
            cnt <= 0;
        end else if (st == 0) begin
            if (cnt < N - 1) cnt <= cnt + 1;
            else st <= 1;
        end else if (st == 1) begin
            if (!req.lvd_active && req.ext_reset_n) begin
                st <= 2;
                sb <= !boot_n;
            end
        end else if (req.lvd_active || !req.ext_reset_n) begin
            st <= 1;
        end else if (st == 2 && deep) begin
            st <= 3;
        end
    end
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", fail_count, checked);
        if (fail_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(negedge clk) begin
        exp_stat = {st < 2, st < 3, st == 2, sb};
        checked++;
        if (stat !== exp_stat) begin
            fail_count++;
            $display("wrong value stat expected %h seen %h cycle %0d", exp_stat, stat, cyc);
        end
        cyc++;
        if (cyc > 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    initial begin
        step(4);
        reset <= 0;
        pin <= 1;
        step(2);
        pin <= 0;
        step(1);
        por <= 0;
        step(20);
        boot <= 1;
        pin <= 1;
        step(2);
        pin <= 0;
        step(rrs_pkg::PIN_LOW_MIN_CYCLES + 10);
        boot <= 0;
        deep <= 1;
        step(5);
        pin <= 1;
        step(1);
        pin <= 0;
        deep <= 0;
        step(rrs_pkg::PIN_LOW_MIN_CYCLES + 10);
        repeat (400) begin
            r = $random(seed);
            lvd <= r[2:0] == 3'h0;
            deep <= r[3];
            boot <= r[4];
            pin <= r[10:5] == 6'h00;
            step(3);
        end
        reset <= 1;
        por <= 1;
        lvd <= 1;
        pin <= 0;
        step(4);
        reset <= 0;
        step(2);
        por <= 0;
        step(15);
        lvd <= 0;
        step(rrs_pkg::PIN_LOW_MIN_CYCLES + 10);
        pin <= 1;
        step(3);
        pin <= 0;
        por <= 1;
        step(3);
        por <= 0;
        deep <= 1;
        step(20);
        por <= 1;
        step(2);
        por <= 0;
        deep <= 0;
        step(20);
        give_verdict();
    end
endmodule
`default_nettype wire
